// [verilog/dchb_pkg.sv]
package dchb_pkg;

  // Register indices (word offsets); byte address is four times the index
  localparam logic [15:0] IDX_MODEL_ID = 16'ha307;
  localparam logic [15:0] IDX_MODEL_LEN = 16'ha308;
  localparam logic [15:0] IDX_CTRL_SRC = 16'ha309;
  localparam logic [15:0] IDX_DEV_HB = 16'ha30a;
  localparam logic [15:0] IDX_HOST_HB = 16'ha30c;
  localparam logic [15:0] IDX_FAULT_CLR = 16'ha30e;
  localparam logic [15:0] IDX_OP_CMD = 16'ha30f;
  // Extra registers for status, interrupts and timeout
  localparam logic [15:0] IDX_STATUS = 16'ha310;
  localparam logic [15:0] IDX_IRQ_STAT = 16'ha311;
  localparam logic [15:0] IDX_IRQ_MASK = 16'ha312;
  localparam logic [15:0] IDX_HB_TIMEOUT = 16'ha313;

  // Model identifier is arbitrary
  localparam logic [15:0] MODEL_ID_VAL = 16'h00a5;
  localparam logic [15:0] MODEL_LEN_VAL = 16'h0007;
  localparam logic [15:0] CTRL_SRC_VAL = 16'h0000;
  localparam logic [31:0] DEV_HB_MAX = 32'h7fffffff;
  localparam logic [31:0] HOST_HB_RST = 32'h00000000;
  localparam logic [15:0] FAULT_CLR_RST = 16'h0000;
  localparam logic [15:0] OP_CMD_RST = 16'h0000;
  localparam logic [15:0] OP_CMD_MAX = 16'h0003;

  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;
  localparam logic [15:0] HB_TIMEOUT_RST = 16'h000a;
  localparam int PRECHARGE_US = 100;
  localparam int PRECHARGE_CYCLES = PRECHARGE_US * (CLK_HZ / 1_000_000);

  // Status and interrupt bit positions
  localparam int ST_COMM_ERR = 0;
  localparam int ST_ARMED = 1;
  localparam int ST_DC_CLOSED = 2;
  localparam int ST_AC_CLOSED = 3;
  localparam int ST_POWER_ON = 4;
  localparam int ST_PRECHARGE = 5;
  localparam int IRQ_COMM_ERR = 0;
  localparam int IRQ_BAD_CMD = 1;
  localparam int IRQ_RUN = 2;
  localparam int IRQ_W = 3;

  typedef enum logic [1:0] {
    DCHB_CMD_STOP, DCHB_CMD_START, DCHB_CMD_STBY_IN, DCHB_CMD_STBY_OUT
  } dchb_cmd_t;

  typedef enum {DCHB_OFF, DCHB_PRECHG, DCHB_RUN, DCHB_STBY} dchb_state_t;

  typedef struct packed {
    logic dc_close;
    logic ac_close;
    logic precharge;
    logic power_on;
  } dchb_ctl_t;

endpackage : dchb_pkg

// [verilog/dchb_regs.sv]
`timescale 1ns/100ps

module dchb_regs
  import dchb_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output dchb_ctl_t ctl_q,
  output logic comm_err_q,
  output logic irq_q
);

  function automatic logic [15:0] word_idx(input logic [31:0] a);
    return a[17:2];
  endfunction : word_idx

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  logic aw_full_q;
  logic w_full_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic [15:0] wr_idx;
  logic wr_ok;

  assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wr_idx = word_idx(awaddr_q);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 32'h00000000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_full_q && !s_axi_awready;
      s_axi_wready <= !w_full_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writes to read-only or unmapped words, and out-of-range enums, get SLVERR
  always_comb begin
    unique case (wr_idx)
      IDX_HOST_HB, IDX_IRQ_MASK, IDX_HB_TIMEOUT: wr_ok = 1'b1;
      IDX_FAULT_CLR: wr_ok = (wdata_q[15:0] <= 16'h0001);
      IDX_OP_CMD: wr_ok = (wdata_q[15:0] <= OP_CMD_MAX);
      default: wr_ok = 1'b0;
    endcase
  end

  logic wr_hb;
  logic wr_fclr;
  logic wr_cmd;
  logic wr_bad_cmd;
  assign wr_hb = wr_fire && wr_idx == IDX_HOST_HB;
  assign wr_fclr = wr_fire && wr_idx == IDX_FAULT_CLR && wr_ok;
  assign wr_cmd = wr_fire && wr_idx == IDX_OP_CMD && wr_ok;
  assign wr_bad_cmd = wr_fire && wr_idx == IDX_OP_CMD && !wr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // One-second prescaler and device heartbeat
  logic [31:0] presc_q;
  logic tick_q;
  logic [31:0] dev_hb_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      presc_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (presc_q == 32'(TICK_LEN - 1)) begin
        presc_q <= 32'h00000000;
        tick_q <= 1'b1;
      end else begin
        presc_q <= presc_q + 32'h00000001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dev_hb_q <= 32'h00000000;
    end else if (tick_q) begin
      dev_hb_q <= (dev_hb_q == DEV_HB_MAX) ? 32'h00000000 : dev_hb_q + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host heartbeat supervision
  logic [31:0] host_hb_q;
  logic [31:0] hb_new;
  logic armed_q;
  logic [15:0] hb_timeout_q;
  logic [15:0] idle_s_q;
  logic hb_seq_bad;
  logic hb_late;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [15:0] fclr_q;
  logic [15:0] op_cmd_q;

  assign hb_new = merge(host_hb_q, wdata_q, wstrb_q);
  // Host must write previous plus one or zero
  assign hb_seq_bad = wr_hb && armed_q && hb_new != 32'h00000000 &&
                      hb_new != host_hb_q + 32'h00000001;
  assign hb_late = armed_q && tick_q && !wr_hb && idle_s_q + 16'h0001 >= hb_timeout_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      host_hb_q <= HOST_HB_RST;
      armed_q <= 1'b0;
      idle_s_q <= 16'h0000;
    end else begin
      if (wr_hb) begin
        host_hb_q <= hb_new;
        armed_q <= 1'b1;
        idle_s_q <= 16'h0000;
      end else if (armed_q && tick_q) begin
        idle_s_q <= (idle_s_q == 16'hffff) ? idle_s_q : idle_s_q + 16'h0001;
      end
    end
  end

  // Latched fault; a new error in the clear cycle wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      comm_err_q <= 1'b0;
    end else if (hb_seq_bad || hb_late) begin
      comm_err_q <= 1'b1;
    end else if (wr_fclr && wdata_q[0]) begin
      comm_err_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fclr_q <= FAULT_CLR_RST;
      op_cmd_q <= OP_CMD_RST;
      hb_timeout_q <= HB_TIMEOUT_RST;
      irq_mask_q <= '0;
    end else if (wr_fire && wr_ok) begin
      if (wr_idx == IDX_FAULT_CLR) fclr_q <= wdata_q[15:0];
      if (wr_idx == IDX_OP_CMD) op_cmd_q <= wdata_q[15:0];
      if (wr_idx == IDX_HB_TIMEOUT) hb_timeout_q <= wdata_q[15:0];
      if (wr_idx == IDX_IRQ_MASK) irq_mask_q <= wdata_q[IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation sequencer; a comm fault forces a stop
  dchb_state_t st_q;
  logic [15:0] pc_cnt_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= DCHB_OFF;
      pc_cnt_q <= 16'h0000;
    end else if (comm_err_q || (wr_cmd && wdata_q[1:0] == DCHB_CMD_STOP)) begin
      st_q <= DCHB_OFF;
    end else begin
      unique case (st_q)
        DCHB_OFF: begin
          if (wr_cmd && wdata_q[1:0] == DCHB_CMD_START) begin
            st_q <= DCHB_PRECHG;
            pc_cnt_q <= 16'h0000;
          end
        end
        DCHB_PRECHG: begin
          if (pc_cnt_q == 16'(PRECHARGE_CYCLES - 1)) st_q <= DCHB_RUN;
          else pc_cnt_q <= pc_cnt_q + 16'h0001;
        end
        DCHB_RUN: begin
          if (wr_cmd && wdata_q[1:0] == DCHB_CMD_STBY_IN) st_q <= DCHB_STBY;
        end
        DCHB_STBY: begin
          if (wr_cmd && wdata_q[1:0] == DCHB_CMD_STBY_OUT) st_q <= DCHB_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctl_q <= '0;
    end else begin
      ctl_q.precharge <= (st_q == DCHB_PRECHG);
      ctl_q.dc_close <= (st_q == DCHB_RUN || st_q == DCHB_STBY);
      ctl_q.ac_close <= (st_q == DCHB_RUN || st_q == DCHB_STBY);
      ctl_q.power_on <= (st_q == DCHB_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky, cleared by reading, set wins over clear
  logic rd_irq_clr;
  logic [IRQ_W-1:0] irq_set;
  assign irq_set = {ctl_q.power_on == 1'b0 && st_q == DCHB_RUN, wr_bad_cmd,
                    hb_seq_bad || hb_late};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= (rd_irq_clr ? '0 : irq_stat_q) | irq_set;
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  logic [31:0] rd_val;
  logic [15:0] rd_idx;
  assign rd_idx = word_idx(s_axi_araddr);
  assign rd_irq_clr = s_axi_arvalid && s_axi_arready && rd_idx == IDX_IRQ_STAT;

  always_comb begin
    rd_val = 32'h00000000;
    unique case (rd_idx)
      IDX_MODEL_ID: rd_val = {16'h0000, MODEL_ID_VAL};
      IDX_MODEL_LEN: rd_val = {16'h0000, MODEL_LEN_VAL};
      IDX_CTRL_SRC: rd_val = {16'h0000, CTRL_SRC_VAL};
      IDX_DEV_HB: rd_val = dev_hb_q;
      IDX_HOST_HB: rd_val = host_hb_q;
      IDX_FAULT_CLR: rd_val = {16'h0000, fclr_q};
      IDX_OP_CMD: rd_val = {16'h0000, op_cmd_q};
      IDX_STATUS: rd_val = {26'h0000000, ctl_q.precharge, ctl_q.power_on, ctl_q.ac_close,
                            ctl_q.dc_close, armed_q, comm_err_q};
      IDX_IRQ_STAT: rd_val = {29'h00000000, irq_stat_q};
      IDX_IRQ_MASK: rd_val = {29'h00000000, irq_mask_q};
      IDX_HB_TIMEOUT: rd_val = {16'h0000, hb_timeout_q};
      default: rd_val = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b0 :
                       (!s_axi_rvalid && !s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= (rd_idx < IDX_MODEL_ID || rd_idx > IDX_HB_TIMEOUT ||
                        rd_idx == 16'ha30b || rd_idx == 16'ha30d) ? 2'h2 : 2'h0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  wrap_to_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick_q && dev_hb_q == DEV_HB_MAX |=> dev_hb_q == 32'h00000000)
    else $error("device heartbeat did not wrap");
  hb_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick_q && dev_hb_q != DEV_HB_MAX |=> dev_hb_q == $past(dev_hb_q) + 32'h00000001)
    else $error("device heartbeat step wrong");
  hb_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !tick_q |=> $stable(dev_hb_q))
    else $error("device heartbeat moved without tick");
  tick_period_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick_q |=> !tick_q)
    else $error("tick longer than one cycle");
  unarmed_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !armed_q && !wr_hb |=> !armed_q && $stable(comm_err_q))
    else $error("supervision acted before first write");
  seq_fault_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hb_seq_bad |=> comm_err_q ##2 !ctl_q.dc_close)
    else $error("bad heartbeat not faulted");
  fault_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_fclr && wdata_q[0] && !hb_seq_bad && !hb_late |=> !comm_err_q)
    else $error("fault reset ignored");
  stop_opens_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_cmd && wdata_q[1:0] == DCHB_CMD_STOP |=> ##1 !ctl_q.dc_close && !ctl_q.ac_close)
    else $error("stop did not open contactors");
  start_prechg_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q == DCHB_OFF && wr_cmd && wdata_q[1:0] == DCHB_CMD_START && !comm_err_q
    |=> ##1 ctl_q.precharge && !ctl_q.dc_close)
    else $error("start did not precharge first");
  stby_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q == DCHB_STBY |=> !ctl_q.power_on)
    else $error("power on during standby");
  len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready && rd_idx == IDX_MODEL_LEN |=> s_axi_rdata == 32'h7)
    else $error("model length wrong");
  late_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hb_late |=> comm_err_q)
    else $error("late heartbeat not faulted");

  cov_wrap_c: cover property (@(posedge clk_sys) tick_q && dev_hb_q == DEV_HB_MAX);
  cov_fault_c: cover property (@(posedge clk_sys) hb_seq_bad);
  cov_run_c: cover property (@(posedge clk_sys) st_q == DCHB_RUN ##1 st_q == DCHB_STBY);
  cov_irq_c: cover property (@(posedge clk_sys) irq_q);

endmodule : dchb_regs

// [verif/dchb_host.sv]
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Host controller model: AXI4-Lite master plus heartbeat bookkeeping
module dchb_host
  import dchb_pkg::*;
(
  input wire logic clk_sys,
  output logic [31:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [31:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  logic [31:0] hb_q = 32'h00000000;

  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Each task starts one edge late so no strobe is assigned twice in a step
  task automatic wr(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= {14'h0000, idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= {14'h0000, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // Legal heartbeat writes only: previous plus one, or zero
  task automatic hb_next(output logic [1:0] r);
    hb_q = hb_q + 32'h1;
    wr(IDX_HOST_HB, hb_q, r);
  endtask : hb_next

  task automatic hb_zero(output logic [1:0] r);
    hb_q = 32'h00000000;
    wr(IDX_HOST_HB, hb_q, r);
  endtask : hb_zero
endmodule : dchb_host

// [verif/testbench.sv]
`timescale 1ns/100ps

module testbench
  import dchb_pkg::*;
;
  // Short tick keeps the run small; every heartbeat wait scales from it
  localparam int TL = 20;
  typedef struct {
    logic wr; logic [15:0] idx; logic [31:0] wd; logic [1:0] wrsp;
    logic [31:0] rd; logic [1:0] rrsp;
  } dchb_row_t;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  dchb_ctl_t ctl_q;
  logic comm_err_q, irq_q;
  logic [31:0] dat, hb1;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int c1, n;
  dchb_row_t rows [9] = '{
    '{1'b0, IDX_MODEL_LEN, 32'h0, 2'h0, 32'h00000007, 2'h0},
    '{1'b0, IDX_CTRL_SRC, 32'h0, 2'h0, 32'h00000000, 2'h0},
    '{1'b1, IDX_CTRL_SRC, 32'h1, 2'h2, 32'h00000000, 2'h0},
    '{1'b0, IDX_HOST_HB, 32'h0, 2'h0, 32'h00000000, 2'h0},
    '{1'b0, IDX_FAULT_CLR, 32'h0, 2'h0, 32'h00000000, 2'h0},
    '{1'b1, IDX_FAULT_CLR, 32'h2, 2'h2, 32'h00000000, 2'h0},
    '{1'b1, IDX_OP_CMD, 32'h4, 2'h2, 32'h00000000, 2'h0},
    '{1'b0, IDX_OP_CMD, 32'h0, 2'h0, 32'h00000000, 2'h0},
    '{1'b0, 16'ha314, 32'h0, 2'h0, 32'h00000000, 2'h2}
  };

  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  dchb_regs #(.TICK_LEN(TL)) dchb_regs_inst (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ctl_q(ctl_q), .comm_err_q(comm_err_q), .irq_q(irq_q)
  );

  dchb_host dchb_host_inst (
    .clk_sys(clk_sys),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    // No host write yet, so a long silence must not fault
    repeat (12 * TL) @(posedge clk_sys);
    chk(32'(comm_err_q), 32'h0);
    $display("test unarmed done");
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        dchb_host_inst.wr(rows[i].idx, rows[i].wd, rsp);
        chk(32'(rsp), 32'(rows[i].wrsp));
      end
      dchb_host_inst.rd(rows[i].idx, dat, rsp);
      chk(dat, rows[i].rd);
      chk(32'(rsp), 32'(rows[i].rrsp));
    end
    $display("test register table done");
    // Read timing varies, so allow the tick count of either neighbouring boundary
    dchb_host_inst.rd(IDX_DEV_HB, hb1, rsp);
    c1 = cyc;
    repeat (5 * TL) @(posedge clk_sys);
    dchb_host_inst.rd(IDX_DEV_HB, dat, rsp);
    n = (cyc - c1) / TL;
    chk(32'((dat - hb1) == n || (dat - hb1) == n + 1), 32'h1);
    $display("test device heartbeat done");
    dchb_host_inst.wr(IDX_HB_TIMEOUT, 32'h2, rsp);
    dchb_host_inst.hb_next(rsp);
    dchb_host_inst.hb_next(rsp);
    chk(32'(comm_err_q), 32'h0);
    dchb_host_inst.wr(IDX_HOST_HB, 32'h5, rsp);
    for (int i = 0; i < 20 && comm_err_q !== 1'b1; i++) @(posedge clk_sys);
    chk(32'(comm_err_q), 32'h1);
    chk(32'(irq_q), 32'h0);
    dchb_host_inst.wr(IDX_IRQ_MASK, 32'h7, rsp);
    repeat (3) @(posedge clk_sys);
    chk(32'(irq_q), 32'h1);
    dchb_host_inst.rd(IDX_IRQ_STAT, dat, rsp);
    chk(dat, 32'h3);
    repeat (3) @(posedge clk_sys);
    chk(32'(irq_q), 32'h0);
    // Restart the heartbeat first, so a late tick cannot re-set the fault after the clear
    dchb_host_inst.hb_zero(rsp);
    dchb_host_inst.wr(IDX_FAULT_CLR, 32'h1, rsp);
    repeat (3) @(posedge clk_sys);
    chk(32'(comm_err_q), 32'h0);
    // Host goes silent past the two-second limit
    repeat (4 * TL) @(posedge clk_sys);
    chk(32'(comm_err_q), 32'h1);
    dchb_host_inst.wr(IDX_HB_TIMEOUT, 32'h00ff, rsp);
    dchb_host_inst.wr(IDX_FAULT_CLR, 32'h1, rsp);
    dchb_host_inst.hb_zero(rsp);
    $display("test host heartbeat done");
    dchb_host_inst.wr(IDX_OP_CMD, 32'h1, rsp);
    repeat (5) @(posedge clk_sys);
    chk(32'({ctl_q.precharge, ctl_q.dc_close}), 32'h2);
    repeat (PRECHARGE_CYCLES + 10) @(posedge clk_sys);
    chk(32'({ctl_q.dc_close, ctl_q.ac_close, ctl_q.power_on}), 32'h7);
    dchb_host_inst.wr(IDX_OP_CMD, 32'h2, rsp);
    repeat (5) @(posedge clk_sys);
    chk(32'(ctl_q.power_on), 32'h0);
    dchb_host_inst.wr(IDX_OP_CMD, 32'h3, rsp);
    repeat (5) @(posedge clk_sys);
    chk(32'(ctl_q.power_on), 32'h1);
    dchb_host_inst.wr(IDX_OP_CMD, 32'h0, rsp);
    repeat (5) @(posedge clk_sys);
    chk(32'({ctl_q.dc_close, ctl_q.ac_close}), 32'h0);
    $display("test operation commands done");
    // Mid-run reset must bring the host heartbeat back to zero
    dchb_host_inst.hb_next(rsp);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    dchb_host_inst.rd(IDX_HOST_HB, dat, rsp);
    chk(dat, 32'h0);
    chk(32'({ctl_q, comm_err_q}), 32'h0);
    $display("test second reset done");
    test_done();
  end

  // Whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    test_done();
  end
endmodule : testbench
